/* hw/nv_timekeeping_sram.sv */
// Summary of operation
// [R1] 512k x 8 memory on byte-wide parallel port
// [R2] Clock registers at the top eight addresses
// [R3] BCD century to seconds, 24-hour hours
// [R4] Month lengths and leap days through 2100
// [R5] Host sees a buffered copy, never mid-update
// [R6] Counting continues during host clock accesses
// [R7] Supply out of tolerance ignores all cycles
// [R8] Readable flag shows backup cell adequate
// [R9] Host drives active-low select, output, write
// [R10] Drive active-low power-on reset output
// [R11] Read-hold bit freezes host copy only
// [R12] Write-hold set, load, clear transfers values
// [R13] Seconds MSB one stops the timebase
// [R14] Data lines driven only on valid reads
`timescale 1ns/1ps
module nv_timekeeping_sram
    import rtc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] address_bus,
    input wire logic [DATA_W-1:0] data_bus_in,
    output logic [DATA_W-1:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_en_n,
    input wire logic supply_ok,
    input wire logic backup_cell,
    output logic por_n
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

    // Step a packed BCD byte by one
    function automatic logic [7:0] bcd_step(input logic [7:0] v);
        bcd_step = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction

    // Last date of a BCD month; year divisible by four is leap, good to 2100
    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        unique case (mon)
            8'h02: month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    endfunction

    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [7:0] cnt_r [8];
    logic [7:0] cnt_nxt [8];
    logic [7:0] ureg_r [8];
    logic [PW-1:0] presc_r;
    logic wr_hold_r, rd_hold_r, timebase_halt_r, ft_r;

    // Access decode; a dead supply blocks every cycle
    wire access = ~chip_sel_n & supply_ok; // [R7] [R9]
    wire wr_take = access & ~wr_en_n;
    wire clk_sel = (address_bus[ADDR_W-1:3] == CLOCK_BASE[ADDR_W-1:3]); // [R2]
    wire [2:0] idx = address_bus[2:0];
    wire ctl_wr = wr_take & clk_sel & (idx == IDX_CENTURY);
    wire new_w = data_bus_in[WRITE_HOLD_BIT];
    wire new_r = data_bus_in[READ_HOLD_BIT];
    wire load = ctl_wr & wr_hold_r & ~new_w; // [R12]
    // Century changes when W is cleared, never while only R is being cleared
    wire cent_upd = ctl_wr & ~new_w & ~new_r & (wr_hold_r | ~rd_hold_r);
    wire frozen = wr_hold_r | rd_hold_r; // [R11]
    wire tick = (presc_r == TICK_LAST) & ~timebase_halt_r; // [R13]
    assign data_bus_oe = access & ~out_en_n & wr_en_n; // [R14]

    // Carry chain of the calendar
    wire c_min = cnt_r[IDX_SECONDS] == SEC_LAST;
    wire c_hr = c_min & (cnt_r[IDX_MINUTES] == SEC_LAST);
    wire c_day = c_hr & (cnt_r[IDX_HOURS] == HOUR_LAST); // [R3]
    wire c_mon = c_day & (cnt_r[IDX_DATE] == month_last(cnt_r[IDX_MONTH], cnt_r[IDX_YEAR])); // [R4]
    wire c_yr = c_mon & (cnt_r[IDX_MONTH] == MONTH_LAST);
    wire c_cen = c_yr & (cnt_r[IDX_YEAR] == YEAR_LAST);

    // Next count after one second
    always_comb begin
        cnt_nxt = cnt_r;
        cnt_nxt[IDX_SECONDS] = c_min ? 8'h00 : bcd_step(cnt_r[IDX_SECONDS]);
        if (c_min) begin
            cnt_nxt[IDX_MINUTES] = c_hr ? 8'h00 : bcd_step(cnt_r[IDX_MINUTES]);
        end
        if (c_hr) begin
            cnt_nxt[IDX_HOURS] = c_day ? 8'h00 : bcd_step(cnt_r[IDX_HOURS]);
        end
        if (c_day) begin
            cnt_nxt[IDX_DAY] = (cnt_r[IDX_DAY] == DAY_LAST) ? FIRST_ONE : bcd_step(cnt_r[IDX_DAY]);
            cnt_nxt[IDX_DATE] = c_mon ? FIRST_ONE : bcd_step(cnt_r[IDX_DATE]);
        end
        if (c_mon) begin
            cnt_nxt[IDX_MONTH] = c_yr ? FIRST_ONE : bcd_step(cnt_r[IDX_MONTH]);
        end
        if (c_yr) begin
            cnt_nxt[IDX_YEAR] = c_cen ? 8'h00 : bcd_step(cnt_r[IDX_YEAR]);
        end
        if (c_cen) begin
            cnt_nxt[IDX_CENTURY] = (cnt_r[IDX_CENTURY] == CENTURY_LAST) ? 8'h00 : bcd_step(cnt_r[IDX_CENTURY]);
        end
    end

    // Prescaler; restarts on a load so the new second starts whole
    always_ff @(posedge mclk) begin
        if (reset || load || presc_r == TICK_LAST) begin
            presc_r <= '0;
        end else if (!timebase_halt_r) begin
            presc_r <= presc_r + PW'(1);
        end
    end

    // Counters never wait on the host; a load overrides a tick, and a direct century write overrides its century field
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r <= CNT_RESET;
        end else if (load) begin
            for (int i = 1; i < 8; i++) begin
                cnt_r[i] <= ureg_r[i] & FIELD_MASK[i]; // [R12]
            end
            cnt_r[IDX_CENTURY] <= data_bus_in & FIELD_MASK[0];
        end else begin
            if (tick) begin
                cnt_r <= cnt_nxt; // [R6]
            end
            if (cent_upd) begin
                cnt_r[IDX_CENTURY] <= data_bus_in & FIELD_MASK[0];
            end
        end
    end

    // Host copy follows the counters unless a hold bit is set
    always_ff @(posedge mclk) begin
        if (reset) begin
            ureg_r <= CNT_RESET;
        end else if (!frozen) begin
            ureg_r <= cnt_r; // [R5]
        end else if (wr_take && clk_sel && idx != IDX_CENTURY) begin
            ureg_r[idx] <= data_bus_in & FIELD_MASK[idx];
        end
    end

    // Control flops; halt and test bits live outside the copied fields
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_hold_r <= 1'b0;
            rd_hold_r <= 1'b0;
            timebase_halt_r <= 1'b0;
            ft_r <= 1'b0;
        end else begin
            if (ctl_wr) begin
                wr_hold_r <= new_w;
                rd_hold_r <= new_r; // [R11]
            end
            if (wr_take && clk_sel && idx == IDX_SECONDS) begin
                timebase_halt_r <= data_bus_in[HALT_BIT]; // [R13]
            end
            if (wr_take && clk_sel && idx == IDX_DAY) begin
                ft_r <= data_bus_in[FREQ_TEST_BIT];
            end
        end
    end

    // Clock location read view
    logic [7:0] clk_view;
    always_comb begin
        clk_view = ureg_r[idx];
        unique case (idx)
            IDX_CENTURY: clk_view = {wr_hold_r, rd_hold_r, ureg_r[idx][5:0]};
            IDX_SECONDS: clk_view = {timebase_halt_r, ureg_r[idx][6:0]};
            IDX_DAY: clk_view = {backup_cell, ft_r, 3'h0, ureg_r[idx][2:0]}; // [R8]
            default: clk_view = ureg_r[idx];
        endcase
    end

    // Memory array is never reset; its content is meant to persist
    always_ff @(posedge mclk) begin
        if (wr_take && !clk_sel) begin
            mem[address_bus] <= data_bus_in; // [R1]
        end
    end

    // Read data registered every cycle; one cycle of access latency
    always_ff @(posedge mclk) begin
        if (reset) begin
            data_bus_out <= '0;
        end else begin
            data_bus_out <= clk_sel ? clk_view : mem[address_bus];
        end
    end

    // Power-on reset output follows the supply monitor
    always_ff @(posedge mclk) begin
        if (reset) begin
            por_n <= 1'b0;
        end else begin
            por_n <= supply_ok; // [R10]
        end
    end

    chk_deselect_quiet: assert property (@(posedge mclk) disable iff (reset) // [R7]
        !supply_ok |-> !data_bus_oe && !load) else $error("bus active with supply out of tolerance");
    chk_drive_window: assert property (@(posedge mclk) disable iff (reset) // [R14]
        data_bus_oe |-> !chip_sel_n && !out_en_n && wr_en_n) else $error("data driven outside read");
    chk_mem_store: assert property (@(posedge mclk) disable iff (reset) // [R1]
        wr_take && !clk_sel |=> mem[$past(address_bus)] == $past(data_bus_in)) else $error("memory write lost");
    chk_copy_track: assert property (@(posedge mclk) disable iff (reset) // [R5]
        !frozen |=> ureg_r[IDX_SECONDS] == $past(cnt_r[IDX_SECONDS])) else $error("copy not following count");
    chk_freeze_hold: assert property (@(posedge mclk) disable iff (reset) // [R11]
        rd_hold_r && !wr_hold_r && !wr_take |=> $stable(ureg_r[IDX_MINUTES])) else $error("frozen copy changed");
    chk_count_runs: assert property (@(posedge mclk) disable iff (reset) // [R6]
        tick && !load && frozen |=> cnt_r[IDX_SECONDS] != $past(cnt_r[IDX_SECONDS])) else $error("count stalled");
    chk_halt_stops: assert property (@(posedge mclk) disable iff (reset) // [R13]
        timebase_halt_r && !load ##1 !load |-> $stable(cnt_r[IDX_SECONDS])) else $error("halted timebase moved");
    chk_load_set: assert property (@(posedge mclk) disable iff (reset) // [R12]
        load |=> cnt_r[IDX_HOURS] == ($past(ureg_r[IDX_HOURS]) & FIELD_MASK[3]) && !wr_hold_r)
        else $error("set values not transferred");
    chk_hour_range: assert property (@(posedge mclk) disable iff (reset) // [R3]
        cnt_r[IDX_HOURS] <= HOUR_LAST |=> cnt_r[IDX_HOURS] <= HOUR_LAST) else $error("hour beyond 23");
    chk_feb_end: assert property (@(posedge mclk) disable iff (reset) // [R4]
        tick && !load && c_day && cnt_r[IDX_MONTH] == 8'h02 && cnt_r[IDX_DATE] == 8'h28 && cnt_r[IDX_YEAR] == 8'h23
        |=> cnt_r[IDX_DATE] == FIRST_ONE && cnt_r[IDX_MONTH] == 8'h03) else $error("month roll wrong");
    chk_flag_view: assert property (@(posedge mclk) disable iff (reset) // [R8]
        clk_sel && idx == IDX_DAY |=> data_bus_out[CELL_FLAG_BIT] == $past(backup_cell)) else $error("cell flag wrong");
    chk_por_follow: assert property (@(posedge mclk) disable iff (reset) // [R10]
        !supply_ok |=> !por_n) else $error("reset output not asserted");
    chk_top_decode: assert property (@(posedge mclk) disable iff (reset) // [R2]
        wr_take && clk_sel && idx == IDX_SECONDS |=> timebase_halt_r == $past(data_bus_in[HALT_BIT]))
        else $error("clock location write missed");
endmodule // nv_timekeeping_sram

/* hw/rtc_pkg.sv */
package rtc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    // Clock locations sit at the top eight addresses; index = address low bits
    localparam logic [18:0] CLOCK_BASE = 19'h7fff8;
    localparam logic [2:0] IDX_CENTURY = 3'h0;
    localparam logic [2:0] IDX_SECONDS = 3'h1;
    localparam logic [2:0] IDX_MINUTES = 3'h2;
    localparam logic [2:0] IDX_HOURS = 3'h3;
    localparam logic [2:0] IDX_DAY = 3'h4;
    localparam logic [2:0] IDX_DATE = 3'h5;
    localparam logic [2:0] IDX_MONTH = 3'h6;
    localparam logic [2:0] IDX_YEAR = 3'h7;
    // Bit positions of the control and flag bits
    localparam int WRITE_HOLD_BIT = 7;
    localparam int READ_HOLD_BIT = 6;
    localparam int HALT_BIT = 7;
    localparam int CELL_FLAG_BIT = 7;
    localparam int FREQ_TEST_BIT = 6;
    // Writable BCD field of each location, indexed as above
    localparam logic [7:0] FIELD_MASK [8] = '{8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
    // Counter values after reset: 00-00-00, day 1, 01/01, century 00
    localparam logic [7:0] CNT_RESET [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    // Field limits in BCD
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] DAY_LAST = 8'h07;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] CENTURY_LAST = 8'h39;
    localparam logic [7:0] FIRST_ONE = 8'h01;
    // One second of count time
    localparam longint SECOND_NS = 1000000000;
    localparam longint CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_CYCLES_DEF = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

/* sim/host_bus_model.sv */
`timescale 1ns/1ps
// Host side of the byte-wide port; every pin moves 1 ns after a rising edge
module host_bus_model
    import rtc_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] address_bus,
    output logic [DATA_W-1:0] data_bus_in,
    input wire logic [DATA_W-1:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_en_n
);
    logic [DATA_W-1:0] drv = 8'h00;
    // Released lines show the inverse of the last byte so a stale value never passes
    assign data_bus_in = data_bus_oe ? data_bus_out : drv;
    initial begin
        address_bus = '0;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        wr_en_n = 1'b1;
    end
    // One access held through its taking edge; controls are active low
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic w);
        address_bus = a;
        drv = w ? d : ~drv;
        chip_sel_n = 1'b0;
        out_en_n = w;
        wr_en_n = !w;
        @(posedge mclk);
        #1;
    endtask
    // Deselect for one cycle
    task automatic idle();
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        wr_en_n = 1'b1;
        drv = ~drv;
        @(posedge mclk);
        #1;
    endtask
endmodule // host_bus_model

/* sim/nv_timekeeping_sram_test.sv */
`timescale 1ns/1ps
module nv_timekeeping_sram_test;
    import rtc_pkg::*;
    localparam int TK = 20;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b1;
    logic backup_cell = 1'b1;
    logic [ADDR_W-1:0] address_bus;
    logic [DATA_W-1:0] data_bus_in, data_bus_out;
    logic data_bus_oe, chip_sel_n, out_en_n, wr_en_n, por_n;
    int fails = 0, checked = 0, cyc = 0;
    // Short second so several rollovers fit in a brief run
    always #5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    nv_timekeeping_sram #(.TICK_CYCLES(TK)) dut (.mclk(mclk), .reset(reset), .address_bus(address_bus),
        .data_bus_in(data_bus_in), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .supply_ok(supply_ok),
        .backup_cell(backup_cell), .por_n(por_n));
    host_bus_model host (.mclk(mclk), .address_bus(address_bus), .data_bus_in(data_bus_in),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .wr_en_n(wr_en_n));
    task automatic wrap_up();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bounded wait on the free-running cycle count
    task automatic wait_to(input int t);
        for (int i = 0; i < 2000 && cyc < t; i++) begin
            @(posedge mclk);
            #1;
        end
        if (cyc < t) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        host.put(a, d, 1'b1);
        cmp("write drive", 8'h00, {7'h0, data_bus_oe});
    endtask
    task automatic rd(input logic [18:0] a, input logic eo, output logic [7:0] d);
        host.put(a, 8'h00, 1'b0);
        cmp("read drive", {7'h0, eo}, {7'h0, data_bus_oe});
        d = data_bus_out;
    endtask
    task automatic test_mem();
        logic [7:0] d;
        wr(19'h00000, 8'ha5);
        wr(19'h7fff7, 8'h5a);
        rd(19'h00000, 1'b1, d);
        cmp("low byte", 8'ha5, d);
        rd(19'h7fff7, 1'b1, d);
        cmp("top memory byte", 8'h5a, d);
        host.idle();
        $display("memory test done");
    endtask
    // A write while the supply is bad must leave the byte alone
    task automatic test_power();
        logic [7:0] d;
        supply_ok = 1'b0;
        wr(19'h00000, 8'h3c);
        cmp("reset out low", 8'h00, {7'h0, por_n});
        rd(19'h00000, 1'b0, d);
        supply_ok = 1'b1;
        host.idle();
        cmp("reset out high", 8'h01, {7'h0, por_n});
        rd(19'h00000, 1'b1, d);
        cmp("protected byte", 8'ha5, d);
        host.idle();
        $display("power test done");
    endtask
    // Set through the write hold, let two seconds roll, then freeze and read the copy
    task automatic test_cal(input logic [63:0] set, input logic [63:0] exp, input logic [7:0] late,
        input logic bc);
        logic [7:0] d;
        logic [7:0] e;
        int e0;
        backup_cell = bc;
        host.put(CLOCK_BASE, 8'h80, 1'b1);
        for (int i = 1; i < 8; i++) begin
            host.put(CLOCK_BASE + 19'(i), set[8*i+:8], 1'b1);
        end
        host.put(CLOCK_BASE, set[7:0], 1'b1);
        e0 = cyc;
        host.idle();
        wait_to(e0 + 2 * TK + 4);
        host.put(CLOCK_BASE, 8'h40, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rd(CLOCK_BASE + 19'(i), 1'b1, d);
            e = exp[8*i+:8] | (i == 0 ? 8'h40 : 8'h00) | (i == 4 ? {bc, 7'h00} : 8'h00);
            cmp("clock field", e, d);
        end
        // Release lands mid-second: five ticks done, the sixth well clear of the read
        wait_to(e0 + 5 * TK + 14);
        rd(CLOCK_BASE + 19'h1, 1'b1, d);
        cmp("frozen seconds", exp[15:8], d);
        host.put(CLOCK_BASE, 8'h00, 1'b1);
        host.idle();
        rd(CLOCK_BASE + 19'h1, 1'b1, d);
        cmp("seconds after hold", late, d);
        rd(CLOCK_BASE, 1'b1, d);
        cmp("century kept", exp[7:0], d);
        // With neither hold bit set a century write with W and R both zero goes straight to the counter
        host.put(CLOCK_BASE, 8'h15, 1'b1);
        host.idle();
        rd(CLOCK_BASE, 1'b1, d);
        cmp("direct century", 8'h15, d);
        host.idle();
        $display("calendar test done");
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        cmp("reset out in reset", 8'h00, {7'h0, por_n});
        repeat (6) @(posedge mclk);
        #1;
        reset = 1'b0;
        host.idle();
        test_mem();
        test_power();
        // Fields packed year down to century; leap day, century rollover, plain year, halted timebase
        // The last case also sets the stored test bit of the day location
        test_cal(64'h24022807_23595820, 64'h24022901_00000020, 8'h03, 1'b1);
        test_cal(64'h99123103_23595820, 64'h00010104_00000021, 8'h03, 1'b0);
        test_cal(64'h23022805_23595820, 64'h23030106_00000020, 8'h03, 1'b1);
        test_cal(64'h24061542_12309020, 64'h24061542_12309020, 8'h90, 1'b1);
        wrap_up();
    end
endmodule // nv_timekeeping_sram_test
